// ---- rtl/twsa_serial.sv ----
// Function
// - 8 bits per unit, one bit per serial clock.
// - next bit out on falling clock; shifter msb drives data out pin.
// - data in captured on rising clock.
// - after 8 bits (plain) or the last byte (auto), halt and set done flag.
// - shift write forces data out low.
// - mode bit 6 reverses bus bit order.
// - write starts only if enabled and clock idle.
// - enabling after a disabled write starts nothing.
// - enable bit 7 low stops, clears counter, frees data pin, and frees clock pin unless idle control is set.
// - auto bit picks plain or multi-byte mode.
// - idle control holds clock pin high when disabled.
// - clock select: external, divide by 4, 8 or 16.
// - auto mode moves up to 32 bytes with ram.
// - auto mode honours peripheral busy handshake.
// - auto active sets on shift write, clears at end.
// - handshake off leaves busy pin a port.
`timescale 1ns/1ps
`default_nettype none

module twsa_serial #(
    parameter logic [twsa_pkg::RAM_ADDR_W-1:0] TX_BASE = 8'h00,
    parameter logic [twsa_pkg::RAM_ADDR_W-1:0] RX_BASE = 8'h20
) (
    input wire logic clk,
    input wire logic nrst,
    input wire logic [twsa_pkg::ADDR_W-1:0] cpu_addr,
    input wire logic cpu_wr,
    input wire logic cpu_rd,
    input wire logic [twsa_pkg::DATA_W-1:0] cpu_wdata,
    output logic [twsa_pkg::DATA_W-1:0] cpu_rdata,
    input wire logic irq_ack,
    output logic transfer_done_irq_flag,
    input wire logic sck_in,
    output logic sck_out,
    output logic sck_oe_n,
    output logic so_out,
    output logic so_oe_n,
    input wire logic si_in,
    input wire logic busy_in,
    output logic busy_pin_in_use,
    output logic [twsa_pkg::RAM_ADDR_W-1:0] ram_addr,
    output logic ram_rd,
    input wire logic [twsa_pkg::DATA_W-1:0] ram_rdata,
    output logic ram_wr,
    output logic [twsa_pkg::DATA_W-1:0] ram_wdata
);
    import twsa_pkg::*;

    // ==========================================================
    // state
    twsa_state_t state_q, state_d;
    logic [7:0] mode_q, mode_d;
    logic [7:0] auto_q, auto_d;
    logic [COUNT_W-1:0] count_q, count_d;
    logic active_q, active_d;
    logic [7:0] shift_q, shift_d;
    logic [BIT_CNT_W-1:0] bit_cnt_q, bit_cnt_d;
    logic [COUNT_W-1:0] byte_idx_q, byte_idx_d;
    logic sck_lvl_q, sck_lvl_d;
    logic sck_prev_q;
    logic so_q, so_d;
    logic irq_q, irq_d;
    logic [RAM_ADDR_W-1:0] ram_addr_q, ram_addr_d;
    logic ram_rd_q, ram_rd_d;
    logic ram_wr_q, ram_wr_d;
    logic [7:0] ram_wdata_q, ram_wdata_d;
    logic [7:0] rdata_q, rdata_d;
    logic sck_out_q, sck_out_d;
    logic sck_oe_n_q, sck_oe_n_d;
    logic so_oe_n_q, so_oe_n_d;
    logic busy_use_q, busy_use_d;

    // ==========================================================
    // decoded controls
    logic enable, first_lsb, auto_sel, idle_ctrl, ext_clk;
    logic hs_en, hs_pol, rx_en, busy_act;
    logic fall_ev, rise_ev, shift_wr, start_ok, last_bit;
    logic [7:0] wdata_rev, shift_rev, ram_rev;

    assign enable = mode_q[MODE_ENABLE_BIT];
    assign first_lsb = mode_q[MODE_FIRST_BIT];
    assign auto_sel = mode_q[MODE_AUTO_BIT];
    assign idle_ctrl = mode_q[MODE_IDLE_CTRL_BIT];
    assign ext_clk = (mode_q[MODE_CSEL_HI:MODE_CSEL_LO] == CLK_SEL_EXT);
    assign hs_en = auto_q[AUTO_HS_EN_BIT];
    assign hs_pol = auto_q[AUTO_HS_POL_BIT];
    assign rx_en = auto_q[AUTO_RX_EN_BIT];

    // busy counts only when enabled; polarity inverts it
    assign busy_act = hs_en & (busy_in ^ hs_pol);

    // ==========================================================
    // bit order reversal for bus and buffer access
    // shifter always runs msb first; only the bus and buffer views are mirrored
    genvar gi;
    generate
        for (gi = 0; gi < BITS_PER_UNIT; gi++) begin : g_rev
            assign wdata_rev[gi] = cpu_wdata[BITS_PER_UNIT-1-gi];
            assign shift_rev[gi] = shift_q[BITS_PER_UNIT-1-gi];
            assign ram_rev[gi] = ram_rdata[BITS_PER_UNIT-1-gi];
        end
    endgenerate

    // ==========================================================
    // serial clock source
    twsa_div_if dif ();

    assign dif.sel = mode_q[MODE_CSEL_HI:MODE_CSEL_LO];
    assign dif.run = enable & ~ext_clk & (state_q == ST_SHIFT);

    twsa_clk_div u_div (
        .clk(clk),
        .nrst(nrst),
        .dif(dif)
    );

    // edges from divider or sampled clock pin
    // pin input is taken as already synchronous to clk
    assign fall_ev = ext_clk ? (sck_prev_q & ~sck_in) : (dif.tick & sck_lvl_q);
    assign rise_ev = ext_clk ? (~sck_prev_q & sck_in) : (dif.tick & ~sck_lvl_q);
    assign shift_wr = cpu_wr & (cpu_addr == ADDR_SHIFT);
    // stopped shifter means internal clock idles high
    assign start_ok = enable & (state_q == ST_IDLE) & (~ext_clk | sck_in);
    assign last_bit = (bit_cnt_q == BIT_CNT_LAST);

    // ==========================================================
    // next-state logic for registers, shifter and auto sequencer
    always_comb begin
        state_d = state_q;
        mode_d = mode_q;
        auto_d = auto_q;
        count_d = count_q;
        active_d = active_q;
        shift_d = shift_q;
        bit_cnt_d = bit_cnt_q;
        byte_idx_d = byte_idx_q;
        sck_lvl_d = sck_lvl_q;
        so_d = so_q;
        irq_d = irq_q;
        ram_addr_d = ram_addr_q;
        ram_rd_d = 1'b0;
        ram_wr_d = 1'b0;
        ram_wdata_d = ram_wdata_q;
        rdata_d = rdata_q;

        // register writes; reserved bits stay zero
        if (cpu_wr && cpu_addr == ADDR_MODE) begin
            mode_d = cpu_wdata & MODE_WR_MASK;
        end
        if (cpu_wr && cpu_addr == ADDR_AUTO) begin
            auto_d = cpu_wdata & AUTO_WR_MASK;
        end
        if (cpu_wr && cpu_addr == ADDR_COUNT) begin
            count_d = cpu_wdata[COUNT_W-1:0];
        end

        // ack first so a same-cycle completion wins
        if (irq_ack) begin
            irq_d = 1'b0;
        end

        case (state_q)
            ST_IDLE: begin
                // a write always loads; it only starts when allowed, never later
                if (shift_wr) begin
                    shift_d = first_lsb ? wdata_rev : cpu_wdata;
                    so_d = 1'b0;
                    if (start_ok) begin
                        bit_cnt_d = '0;
                        if (auto_sel) begin
                            active_d = 1'b1;
                            byte_idx_d = '0;
                            state_d = ST_FETCH;
                        end else begin
                            state_d = ST_SHIFT;
                        end
                    end
                end
            end
            ST_FETCH: begin
                // buffer read; data returns a cycle after ram_rd
                ram_rd_d = 1'b1;
                ram_addr_d = TX_BASE + RAM_ADDR_W'(byte_idx_q);
                state_d = ST_RDWAIT;
            end
            ST_RDWAIT: begin
                state_d = ST_LOAD;
            end
            ST_LOAD: begin
                shift_d = first_lsb ? ram_rev : ram_rdata;
                so_d = 1'b0;
                state_d = ST_HOLD;
            end
            ST_HOLD: begin
                // clock parked high until peripheral ready
                if (!busy_act) begin
                    bit_cnt_d = '0;
                    state_d = ST_SHIFT;
                end
            end
            ST_SHIFT: begin
                if (fall_ev) begin
                    sck_lvl_d = 1'b0;
                    so_d = shift_q[BITS_PER_UNIT-1];
                end
                if (rise_ev) begin
                    sck_lvl_d = 1'b1;
                    shift_d = {shift_q[BITS_PER_UNIT-2:0], si_in};
                    bit_cnt_d = bit_cnt_q + 4'h1;
                    if (last_bit) begin
                        bit_cnt_d = '0;
                        if (auto_sel) begin
                            state_d = ST_STORE;
                        end else begin
                            irq_d = 1'b1;
                            state_d = ST_IDLE;
                        end
                    end
                end
            end
            ST_STORE: begin
                if (rx_en) begin
                    ram_wr_d = 1'b1;
                    ram_addr_d = RX_BASE + RAM_ADDR_W'(byte_idx_q);
                    ram_wdata_d = first_lsb ? shift_rev : shift_q;
                end
                if (byte_idx_q == count_q) begin
                    active_d = 1'b0;
                    irq_d = 1'b1;
                    state_d = ST_IDLE;
                end else begin
                    byte_idx_d = byte_idx_q + 5'h01;
                    state_d = ST_FETCH;
                end
            end
            default: begin
                state_d = ST_IDLE;
            end
        endcase

        // disabling aborts and clears the bit counter
        if (!enable) begin
            state_d = ST_IDLE;
            bit_cnt_d = '0;
            sck_lvl_d = 1'b1;
            active_d = 1'b0;
        end

        // reads answer a cycle later; unmapped read zero
        if (cpu_rd) begin
            case (cpu_addr)
                ADDR_MODE: rdata_d = mode_q;
                ADDR_AUTO: rdata_d = auto_q | (8'(active_q) << AUTO_ACTIVE_BIT);
                ADDR_SHIFT: rdata_d = first_lsb ? shift_rev : shift_q;
                ADDR_COUNT: rdata_d = 8'(count_q);
                default: rdata_d = READ_ZERO;
            endcase
        end
    end

    // ==========================================================
    // pin control, registered so pins change on clean edges
    // clock pin driven for an internal clock, or while disabled with idle control set
    always_comb begin
        sck_out_d = enable ? sck_lvl_d : 1'b1;
        sck_oe_n_d = ~((enable & ~ext_clk) | (~enable & idle_ctrl));
        so_oe_n_d = ~enable;
        busy_use_d = enable & hs_en;
    end

    // ==========================================================
    // registers
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            state_q <= ST_IDLE;
            mode_q <= MODE_RESET;
            auto_q <= AUTO_RESET;
            count_q <= COUNT_RESET;
            active_q <= 1'b0;
            shift_q <= 8'h00;
            bit_cnt_q <= '0;
            byte_idx_q <= '0;
            sck_lvl_q <= 1'b1;
            sck_prev_q <= 1'b1;
            so_q <= 1'b0;
            irq_q <= 1'b0;
            ram_addr_q <= '0;
            ram_rd_q <= 1'b0;
            ram_wr_q <= 1'b0;
            ram_wdata_q <= 8'h00;
            rdata_q <= 8'h00;
            sck_out_q <= 1'b1;
            sck_oe_n_q <= 1'b1;
            so_oe_n_q <= 1'b1;
            busy_use_q <= 1'b0;
        end else begin
            state_q <= state_d;
            mode_q <= mode_d;
            auto_q <= auto_d;
            count_q <= count_d;
            active_q <= active_d;
            shift_q <= shift_d;
            bit_cnt_q <= bit_cnt_d;
            byte_idx_q <= byte_idx_d;
            sck_lvl_q <= sck_lvl_d;
            sck_prev_q <= sck_in;
            so_q <= so_d;
            irq_q <= irq_d;
            ram_addr_q <= ram_addr_d;
            ram_rd_q <= ram_rd_d;
            ram_wr_q <= ram_wr_d;
            ram_wdata_q <= ram_wdata_d;
            rdata_q <= rdata_d;
            sck_out_q <= sck_out_d;
            sck_oe_n_q <= sck_oe_n_d;
            so_oe_n_q <= so_oe_n_d;
            busy_use_q <= busy_use_d;
        end
    end

    // ==========================================================
    // outputs
    assign cpu_rdata = rdata_q;
    assign transfer_done_irq_flag = irq_q;
    assign sck_out = sck_out_q;
    assign sck_oe_n = sck_oe_n_q;
    assign so_out = so_q;
    assign so_oe_n = so_oe_n_q;
    assign busy_pin_in_use = busy_use_q;
    assign ram_addr = ram_addr_q;
    assign ram_rd = ram_rd_q;
    assign ram_wr = ram_wr_q;
    assign ram_wdata = ram_wdata_q;

endmodule

`default_nettype wire

// ---- rtl/twsa_pkg.sv ----
package twsa_pkg;

    // ==========================================================
    // cpu register port
    localparam int ADDR_W = 16;
    localparam int DATA_W = 8;
    localparam logic [15:0] ADDR_SHIFT = 16'hff62;
    localparam logic [15:0] ADDR_MODE = 16'hff63;
    localparam logic [15:0] ADDR_AUTO = 16'hff64;
    localparam logic [15:0] ADDR_COUNT = 16'hff66;
    localparam logic [7:0] MODE_RESET = 8'h00;
    localparam logic [7:0] AUTO_RESET = 8'h00;
    localparam logic [4:0] COUNT_RESET = 5'h00;
    localparam logic [7:0] READ_ZERO = 8'h00;

    // ==========================================================
    // serial_mode_control fields
    localparam int MODE_ENABLE_BIT = 7;
    localparam int MODE_FIRST_BIT = 6;
    localparam int MODE_AUTO_BIT = 5;
    localparam int MODE_IDLE_CTRL_BIT = 4;
    localparam int MODE_CSEL_HI = 1;
    localparam int MODE_CSEL_LO = 0;
    localparam logic [7:0] MODE_WR_MASK = 8'hf3;

    // ==========================================================
    // auto_transfer_control fields
    localparam int AUTO_RX_EN_BIT = 7;
    localparam int AUTO_ACTIVE_BIT = 3;
    localparam int AUTO_HS_EN_BIT = 1;
    localparam int AUTO_HS_POL_BIT = 0;
    localparam logic [7:0] AUTO_WR_MASK = 8'he3;
    localparam int COUNT_W = 5;

    // ==========================================================
    // shifter, clock select, buffer addressing
    localparam int BITS_PER_UNIT = 8;
    localparam int BIT_CNT_W = 4;
    localparam logic [3:0] BIT_CNT_LAST = 4'h7;
    localparam int CSEL_W = 2;
    localparam logic [1:0] CLK_SEL_EXT = 2'h0;
    localparam logic [1:0] CLK_SEL_DIV4 = 2'h1;
    localparam logic [1:0] CLK_SEL_DIV8 = 2'h2;
    localparam logic [1:0] CLK_SEL_DIV16 = 2'h3;
    localparam int DIV_CNT_W = 3;
    localparam logic [2:0] HALF_DIV4 = 3'h1;
    localparam logic [2:0] HALF_DIV8 = 3'h3;
    localparam logic [2:0] HALF_DIV16 = 3'h7;
    localparam int RAM_ADDR_W = 8;

    typedef enum logic [2:0] {
        ST_IDLE, ST_FETCH, ST_RDWAIT, ST_LOAD, ST_HOLD, ST_SHIFT, ST_STORE
    } twsa_state_t;

endpackage

// ---- rtl/twsa_div_if.sv ----
`timescale 1ns/1ps
`default_nettype none

// ==========================================================
// serial clock divider hookup
interface twsa_div_if;
    logic [twsa_pkg::CSEL_W-1:0] sel;
    logic run;
    logic tick;
    modport ctrl (output sel, output run, input tick);
    modport div (input sel, input run, output tick);
endinterface

`default_nettype wire

// ---- rtl/twsa_clk_div.sv ----
`timescale 1ns/1ps
`default_nettype none

module twsa_clk_div (
    input wire logic clk,
    input wire logic nrst,
    twsa_div_if.div dif
);
    import twsa_pkg::*;

    logic [DIV_CNT_W-1:0] cnt_q, cnt_d;
    logic [DIV_CNT_W-1:0] term;
    logic tick_q, tick_d;

    // ==========================================================
    // half-period counter
    // restart at zero when stopped: full first half-period
    always_comb begin
        case (dif.sel)
            CLK_SEL_DIV4: term = HALF_DIV4;
            CLK_SEL_DIV8: term = HALF_DIV8;
            CLK_SEL_DIV16: term = HALF_DIV16;
            default: term = HALF_DIV4;
        endcase
        if (!dif.run) begin
            cnt_d = '0;
            tick_d = 1'b0;
        end else if (cnt_q == term) begin
            cnt_d = '0;
            tick_d = 1'b1;
        end else begin
            cnt_d = cnt_q + 3'h1;
            tick_d = 1'b0;
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            cnt_q <= '0;
            tick_q <= 1'b0;
        end else begin
            cnt_q <= cnt_d;
            tick_q <= tick_d;
        end
    end

    assign dif.tick = tick_q;

endmodule

`default_nettype wire

// ---- verif/twsa_serial_monitor.sv ----
`timescale 1ns/1ps
`default_nettype none

// ==========================================================
// port checker
module twsa_serial_monitor #(
    parameter logic [twsa_pkg::RAM_ADDR_W-1:0] TX_BASE = 8'h00
) (
    input wire logic clk,
    input wire logic nrst,
    input wire logic [twsa_pkg::ADDR_W-1:0] cpu_addr,
    input wire logic cpu_wr,
    input wire logic [twsa_pkg::DATA_W-1:0] cpu_wdata,
    input wire logic transfer_done_irq_flag,
    input wire logic sck_in,
    input wire logic sck_out,
    input wire logic sck_oe_n,
    input wire logic so_out,
    input wire logic so_oe_n,
    input wire logic busy_in,
    input wire logic busy_pin_in_use,
    input wire logic [twsa_pkg::RAM_ADDR_W-1:0] ram_addr,
    input wire logic ram_rd
);
    import twsa_pkg::*;
    logic en_q, idle_q, auto_q, hs_en_q, hs_pol_q, xfer_q, flag_q, sck_q, rd_seen_q, start, park;
    logic [1:0] sel_q;
    logic [4:0] cnt_q;
    logic [8:0] fall_q;
    logic [3:0] low_q, half;
    logic [7:0] rd_addr_q;

    // start, park and expected low phase
    assign start = cpu_wr && cpu_addr == ADDR_SHIFT && en_q && !xfer_q && (sel_q != CLK_SEL_EXT || sck_in);
    assign park = auto_q && hs_en_q && xfer_q && (busy_in ^ hs_pol_q) && sck_out && fall_q[2:0] == 3'h0;
    assign half = (sel_q == CLK_SEL_DIV4) ? 4'h2 : (sel_q == CLK_SEL_DIV8) ? 4'h4 : 4'h8;

    // shadow of written settings
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            {en_q, idle_q, auto_q, hs_en_q, hs_pol_q, xfer_q, flag_q, rd_seen_q} <= 8'h00;
            {sel_q, cnt_q, fall_q, rd_addr_q} <= 24'h000000;
            sck_q <= 1'b1;
            low_q <= 4'h0;
        end else begin
            if (cpu_wr && cpu_addr == ADDR_MODE) begin
                {en_q, auto_q, idle_q, sel_q} <= {cpu_wdata[7], cpu_wdata[5:4], cpu_wdata[1:0]};
            end
            if (cpu_wr && cpu_addr == ADDR_AUTO) begin
                {hs_en_q, hs_pol_q} <= cpu_wdata[1:0];
            end
            if (cpu_wr && cpu_addr == ADDR_COUNT) begin
                cnt_q <= cpu_wdata[4:0];
            end
            flag_q <= transfer_done_irq_flag;
            sck_q <= sck_out;
            low_q <= (sck_out != sck_q) ? 4'h1 : low_q + 4'h1;
            if (start) begin
                xfer_q <= 1'b1;
                fall_q <= 9'h000;
                rd_seen_q <= 1'b0;
            end else begin
                if ((transfer_done_irq_flag && !flag_q) || !en_q) xfer_q <= 1'b0;
                if (sck_q && !sck_out) fall_q <= fall_q + 9'h001;
            end
            if (ram_rd) begin
                rd_seen_q <= 1'b1;
                rd_addr_q <= ram_addr;
            end
        end
    end

    default clocking mon_cb @(posedge clk);
    endclocking
    default disable iff (!nrst);

    AST_SO_LOW_ON_WRITE: assert property (start |=> !so_out)
        else $error("data pin not low after shift write");
    AST_STOPPED_PINS: assert property (!$past(en_q) && !$past(idle_q) |-> so_oe_n && sck_oe_n)
        else $error("pins still driven while stopped");
    AST_IDLE_CLOCK_HIGH: assert property (!$past(en_q) && $past(idle_q) |-> !sck_oe_n && sck_out)
        else $error("clock pin not held high while stopped");
    AST_ENABLED_DRIVE: assert property ($past(en_q) |-> !so_oe_n)
        else $error("data pin not driven while enabled");
    AST_FLAG_BIT_COUNT: assert property ($rose(transfer_done_irq_flag) |->
        fall_q == (auto_q ? {cnt_q, 3'h0} + 9'h008 : 9'h008)) else $error("wrong clock count at done");
    AST_FLAG_CLOCK_IDLE: assert property ($rose(transfer_done_irq_flag) |-> sck_out [*4])
        else $error("clock moves after done");
    AST_DATA_ON_LOW: assert property (!auto_q && xfer_q && $past(xfer_q) && $changed(so_out) |-> !sck_out)
        else $error("data pin changed while clock high");
    AST_BUSY_PIN: assert property (busy_pin_in_use == ($past(en_q) && $past(hs_en_q)))
        else $error("busy pin use wrong");
    AST_PARK_ON_BUSY: assert property (park [*8] |=> !$fell(sck_out))
        else $error("clock started while busy");
    AST_RAM_STEP: assert property (ram_rd |-> ram_addr == (rd_seen_q ? rd_addr_q + 8'h01 : TX_BASE))
        else $error("buffer read address wrong");
    AST_HALF_PERIOD: assert property ($rose(sck_out) && xfer_q && sel_q != CLK_SEL_EXT |-> low_q == half)
        else $error("clock low phase wrong");

    COV_PLAIN_DONE: cover property ($rose(transfer_done_irq_flag) && !auto_q);
    COV_AUTO_DONE: cover property ($rose(transfer_done_irq_flag) && auto_q);
    COV_PARKED: cover property (park [*8]);
endmodule

bind twsa_serial twsa_serial_monitor #(.TX_BASE(TX_BASE)) twsa_serial_monitor_inst (.clk(clk), .nrst(nrst),
    .cpu_addr(cpu_addr), .cpu_wr(cpu_wr), .cpu_wdata(cpu_wdata), .transfer_done_irq_flag(transfer_done_irq_flag),
    .sck_in(sck_in), .sck_out(sck_out), .sck_oe_n(sck_oe_n), .so_out(so_out), .so_oe_n(so_oe_n),
    .busy_in(busy_in), .busy_pin_in_use(busy_pin_in_use), .ram_addr(ram_addr), .ram_rd(ram_rd));

`default_nettype wire

// ---- verif/twsa_periph_model.sv ----
`timescale 1ns/1ps
`default_nettype none

// ==========================================================
// far-side peripheral
module twsa_periph_model (
    input wire logic clk,
    input wire logic nrst,
    input wire logic sck,
    input wire logic so,
    output logic si,
    output logic busy,
    input wire logic busy_req,
    input wire logic pol,
    input wire logic [7:0] tx_byte,
    output logic [7:0] rx_byte,
    output logic rx_done
);
    logic sck_q, act_q, done_q;
    logic [2:0] bit_q;
    logic [7:0] rx_q, tx_q, idx_q;

    // busy in chosen polarity; data inverted outside a byte
    assign busy = pol ? ~busy_req : busy_req;
    assign si = act_q ? tx_q[7] : ~tx_q[7];
    assign rx_byte = rx_q;
    assign rx_done = done_q;

    // next bit on falling clock, capture on rising
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            {sck_q, act_q, done_q, bit_q} <= 6'h20;
            {rx_q, tx_q, idx_q} <= 24'h000000;
        end else begin
            sck_q <= sck;
            done_q <= 1'b0;
            if (sck_q && !sck) begin
                act_q <= 1'b1;
                tx_q <= (bit_q == 3'h0) ? tx_byte + idx_q : {tx_q[6:0], 1'b0};
            end
            if (!sck_q && sck) begin
                rx_q <= {rx_q[6:0], so};
                bit_q <= bit_q + 3'h1;
                if (bit_q == 3'h7) begin
                    done_q <= 1'b1;
                    act_q <= 1'b0;
                    idx_q <= idx_q + 8'h01;
                end
            end
        end
    end
endmodule

`default_nettype wire

// ---- verif/testbench.sv ----
`timescale 1ns/1ps
`default_nettype none

// ==========================================================
// self-checking bench
module testbench;
    import twsa_pkg::*;
    localparam logic [7:0] RXB = 8'h20;
    logic clk = 1'b0, nrst = 1'b0, cpu_wr = 1'b0, cpu_rd = 1'b0, irq_ack = 1'b0, busy_req = 1'b0, pol = 1'b0;
    logic [15:0] cpu_addr = 16'h0000;
    logic [7:0] cpu_wdata = 8'h00, ram_rdata = 8'h00, ptx = 8'h00, cpu_rdata, ram_addr, ram_wdata, rx_byte;
    logic flag, sck_out, sck_oe_n, so_out, so_oe_n, si_in, busy_in, busy_use, ram_rd, ram_wr, rx_done;
    logic rd_seen = 1'b0;
    logic [7:0] mem [64];
    logic [7:0] ex_q[$], rd_q[$];
    logic [15:0] wr_q[$];
    int mismatches = 0, checks_done = 0, nbytes = 0;

    initial forever #2 clk = ~clk;

    twsa_serial #(.TX_BASE(8'h00), .RX_BASE(RXB)) twsa_serial_inst (.clk(clk), .nrst(nrst), .cpu_addr(cpu_addr),
        .cpu_wr(cpu_wr), .cpu_rd(cpu_rd), .cpu_wdata(cpu_wdata), .cpu_rdata(cpu_rdata), .irq_ack(irq_ack),
        .transfer_done_irq_flag(flag), .sck_in(1'b1), .sck_out(sck_out), .sck_oe_n(sck_oe_n), .so_out(so_out),
        .so_oe_n(so_oe_n), .si_in(si_in), .busy_in(busy_in), .busy_pin_in_use(busy_use), .ram_addr(ram_addr),
        .ram_rd(ram_rd), .ram_rdata(ram_rdata), .ram_wr(ram_wr), .ram_wdata(ram_wdata));
    twsa_periph_model twsa_periph_model_inst (.clk(clk), .nrst(nrst), .sck(sck_out), .so(so_out), .si(si_in),
        .busy(busy_in), .busy_req(busy_req), .pol(pol), .tx_byte(ptx), .rx_byte(rx_byte), .rx_done(rx_done));

    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        checks_done++;
        if (got !== exp) begin
            $display("BAD %s expected %h seen %h", what, exp, got);
            mismatches++;
        end
    endtask

    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        @(posedge clk);
        cpu_addr <= a;
        cpu_wdata <= d;
        cpu_wr <= 1'b1;
        @(posedge clk);
        cpu_wr <= 1'b0;
    endtask

    task automatic rd(input logic [15:0] a, input logic [7:0] e);
        rd_q.push_back(e);
        @(posedge clk);
        cpu_addr <= a;
        cpu_rd <= 1'b1;
        @(posedge clk);
        cpu_rd <= 1'b0;
    endtask

    task automatic idle(input int n);
        repeat (n) @(posedge clk);
    endtask

    // bounded wait for done flag, then ack
    task automatic wait_flag();
        int i;
        for (i = 0; i < 3000 && flag !== 1'b1; i++) @(posedge clk);
        if (flag !== 1'b1) begin
            mismatches++;
            end_of_test();
        end else begin
            irq_ack <= 1'b1;
            @(posedge clk);
            irq_ack <= 1'b0;
        end
    endtask

    task automatic end_of_test();
        $display("checks %0d mismatches %0d", checks_done, mismatches);
        if (mismatches == 0 && checks_done > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    function automatic logic [7:0] rev(input logic [7:0] v);
        return {v[0], v[1], v[2], v[3], v[4], v[5], v[6], v[7]};
    endfunction

    // buffer answers a cycle after its strobe; notes popped in order
    always @(posedge clk) begin
        if (ram_rd === 1'b1) ram_rdata <= mem[ram_addr[5:0]];
        if (ram_wr === 1'b1) chk("ram write", wr_q.pop_front(), {ram_addr, ram_wdata});
        if (rx_done === 1'b1) chk("wire byte", {8'h00, ex_q.pop_front()}, {8'h00, rx_byte});
        if (rd_seen) chk("cpu read", {8'h00, rd_q.pop_front()}, {8'h00, cpu_rdata});
        rd_seen <= cpu_rd;
    end

    // main sequence; external clock unused, so handshake never meets it
    initial begin
        int k, s;
        logic [7:0] d, cnt, actl;
        void'($urandom(26));
        for (k = 0; k < 64; k++) mem[k] = 8'($urandom);
        repeat (8) @(posedge clk);
        nrst <= 1'b1;
        rd(ADDR_MODE, MODE_RESET);
        rd(ADDR_AUTO, AUTO_RESET);
        rd(16'hff65, READ_ZERO);
        wr(ADDR_MODE, 8'hff);
        rd(ADDR_MODE, MODE_WR_MASK);
        wr(ADDR_AUTO, 8'hff);
        rd(ADDR_AUTO, AUTO_WR_MASK);
        wr(ADDR_AUTO, 8'h00);
        wr(ADDR_MODE, 8'h10);
        idle(2);
        chk("idle clock pin", 16'h0000, {14'h0, sck_oe_n, ~sck_out});
        wr(ADDR_MODE, 8'h01);
        idle(2);
        chk("stopped pins", 16'h0003, {14'h0, sck_oe_n, so_oe_n});
        wr(ADDR_SHIFT, 8'h3c);
        wr(ADDR_MODE, 8'h81);
        idle(60);
        chk("late start flag", 16'h0000, {15'h0, flag});
        rd(ADDR_SHIFT, 8'h3c);
        $display("test registers done");
        // plain bytes, every internal rate, both orders, order set first
        for (s = 1; s < 4; s++) begin
            for (k = 0; k < 2; k++) begin
                d = 8'($urandom);
                ptx = 8'($urandom);
                wr(ADDR_MODE, {1'b1, k[0], 4'h0, s[1:0]});
                ex_q.push_back(k[0] ? rev(d) : d);
                wr(ADDR_SHIFT, d);
                #1 chk("data pin after write", 16'h0000, {15'h0, so_out});
                wait_flag();
                rd(ADDR_SHIFT, k[0] ? rev(ptx + nbytes[7:0]) : ptx + nbytes[7:0]);
                nbytes++;
            end
        end
        $display("test plain done");
        // auto runs: busy high, busy low, busy ignored
        for (k = 0; k < 3; k++) begin
            cnt = (k == 1) ? 8'h1f : 8'(k * 2);
            actl = (k == 2) ? 8'h80 : {7'h41, k[0]};
            pol = k[0];
            busy_req <= 1'b1;
            wr(ADDR_COUNT, cnt);
            wr(ADDR_AUTO, actl);
            wr(ADDR_MODE, 8'ha1);
            for (s = 0; s <= int'(cnt); s++) begin
                ex_q.push_back(mem[s]);
                wr_q.push_back({RXB + 8'(s), ptx + 8'(nbytes + s)});
            end
            wr(ADDR_SHIFT, 8'h00);
            rd(ADDR_AUTO, actl | 8'h08);
            idle(40);
            if (k < 2) chk("parked clock", 16'h0001, {15'h0, sck_out & ~flag});
            chk("busy pin use", {15'h0, k < 2}, {15'h0, busy_use});
            busy_req <= 1'b0;
            wait_flag();
            rd(ADDR_AUTO, actl);
            nbytes += int'(cnt) + 1;
            $display("test auto %0d done", k);
        end
        idle(4);
        chk("pending notes", 16'h0000, 16'(ex_q.size() + wr_q.size() + rd_q.size()));
        end_of_test();
    end
endmodule

`default_nettype wire
